// *** hw/fpvp_pkg.sv ***
// Package with the constants and types of the vector datapath.
package fpvp_pkg;
  localparam int DATA_W = 32;
  localparam int WIDE_W = 64;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [63:0] RESET_WIDE = 64'h0000_0000_0000_0000;
  // Cycles from operand load to result register, per mode.
  localparam int PIPED_LAT   = 2;
  localparam int UNPIPED_LAT = 1;
  // ALU add-class encodings.
  localparam logic [2:0] ALU_ADD     = 3'h0;
  localparam logic [2:0] ALU_A_SUB_B = 3'h1;
  localparam logic [2:0] ALU_B_SUB_A = 3'h2;
  localparam logic [2:0] ALU_COMPARE = 3'h3;
  // Multiplier variants.
  localparam logic [2:0] MUL_PLAIN     = 3'h0;
  localparam logic [2:0] MUL_NEG       = 3'h1;
  localparam logic [2:0] MUL_ABS_B     = 3'h2;
  localparam logic [2:0] MUL_NEG_ABS_B = 3'h3;
  localparam logic [2:0] MUL_ABS_AB    = 3'h4;
  localparam logic [2:0] MUL_NEG_ABS_AB = 3'h5;
  // Output source select values.
  localparam logic OUT_SUM  = 1'b0;
  localparam logic OUT_PROD = 1'b1;
  typedef enum logic [1:0] {FPVP_UNIT_ALU, FPVP_UNIT_MUL, FPVP_UNIT_CHAIN, FPVP_UNIT_IDLE}
    fpvp_unit_t;
endpackage

// *** hw/fpvp_datapath.sv ***
// Vector add and multiply datapath with optional internal pipeline stage.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Vector add runs on the ALU alone, one operand pair each cycle.
// - Pipelined, the first sum reaches the sum register two cycles after load.
// - Pipelined, N results appear on the output bus on clocks 3 to N+2.
// - Unpiped, N results appear on the output bus on clocks 2 to N+1.
// - A compare produces two status bits and no numeric output.
// - Subtracts and compare share the add timing and programming pattern.
// - Add class covers sums and differences of operands and absolute values.
// - Vector multiply runs on the multiplier alone, one pair each cycle.
// - Multiplier offers negated and absolute-value product variants.
// - A new operand pair is accepted on every clock.
// - Unpiped, each result completes one cycle after its operands load.
// - Chained mode feeds products into the ALU concurrently.
// - Input, pipeline and output registers may each be bypassed.
// - Output multiplexer selects the upper or lower half onto 32 bits.
module fpvp_datapath (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [31:0] operand_a_in,
  input  wire logic [31:0] operand_b_in,
  input  wire logic        load_operands,
  input  wire logic        alu_op_valid,
  input  wire logic [2:0]  alu_func,
  input  wire logic        alu_abs_a,
  input  wire logic        alu_abs_b,
  input  wire logic        multiply_op,
  input  wire logic [2:0]  mul_func,
  input  wire logic        chained_mode,
  input  wire logic        output_source_select_bit,
  input  wire logic        output_high_half,
  input  wire logic        pipeline_enable,
  input  wire logic        bypass_input_regs,
  input  wire logic        bypass_output_regs,
  output logic [31:0]      result_output_bus,
  output logic             result_valid,
  output logic             compare_equal,
  output logic             compare_a_greater,
  output logic             status_valid
);
  logic [31:0] operand_a_input_reg;
  logic [31:0] operand_b_input_reg;
  logic        in_valid;
  logic [63:0] alu_pipe;
  logic [63:0] mul_pipe;
  logic        alu_pipe_v;
  logic        mul_pipe_v;
  logic        alu_pipe_cmp;
  logic        pipe_sel;
  logic        pipe_hi;
  logic [63:0] alu_result_reg;
  logic [63:0] product_result_reg;
  logic        sum_v;
  logic        prod_v;
  logic        out_sel;
  logic        out_hi;
  logic        cmp_eq_r;
  logic        cmp_gt_r;
  logic        cmp_pend;
  logic        cmp_fin;
  logic        mode_piped;
  logic        seq_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Operand selection, with the input registers optionally bypassed.
  wire logic [31:0] op_a = bypass_input_regs ? operand_a_in : operand_a_input_reg;
  wire logic [31:0] op_b = bypass_input_regs ? operand_b_in : operand_b_input_reg;
  wire logic        op_v = bypass_input_regs ? load_operands : in_valid;
  wire logic [31:0] abs_a = op_a[31] ? 32'(-op_a) : op_a;
  wire logic [31:0] abs_b = op_b[31] ? 32'(-op_b) : op_b;
  wire logic [31:0] alu_x = alu_abs_a ? abs_a : op_a;
  wire logic [31:0] alu_y = alu_abs_b ? abs_b : op_b;
  wire logic [63:0] mul_plain = 64'($signed(op_a) * $signed(op_b));
  wire logic [63:0] mul_absb  = 64'($signed(op_a) * $signed({1'b0, abs_b}));
  wire logic [63:0] mul_abs2  = 64'(abs_a * abs_b);
  // Integer arithmetic stands in for the floating point core; timing is exact.
  wire logic [63:0] mul_core =
    (mul_func == fpvp_pkg::MUL_NEG)        ? 64'(-mul_plain) :
    (mul_func == fpvp_pkg::MUL_ABS_B)      ? mul_absb :
    (mul_func == fpvp_pkg::MUL_NEG_ABS_B)  ? 64'(-mul_absb) :
    (mul_func == fpvp_pkg::MUL_ABS_AB)     ? mul_abs2 :
    (mul_func == fpvp_pkg::MUL_NEG_ABS_AB) ? 64'(-mul_abs2) : mul_plain;
  wire logic [63:0] ax64 = {{32{alu_x[31]}}, alu_x};
  wire logic [63:0] ay64 = {{32{alu_y[31]}}, alu_y};
  // Chained mode replaces operand A with the latest product, which the ALU adds to operand B.
  wire logic [63:0] alu_lhs = chained_mode ? product_result_reg : ax64;
  wire logic [63:0] alu_core =
    (alu_func == fpvp_pkg::ALU_A_SUB_B) ? 64'(alu_lhs - ay64) :
    (alu_func == fpvp_pkg::ALU_B_SUB_A) ? 64'(ay64 - alu_lhs) :
    (alu_func == fpvp_pkg::ALU_COMPARE) ? 64'(alu_lhs - ay64) :
    64'(alu_lhs + ay64);
  wire logic        is_cmp = alu_op_valid && (alu_func == fpvp_pkg::ALU_COMPARE);
  wire logic        alu_go = op_v && alu_op_valid;
  wire logic        mul_go = op_v && multiply_op;

  ////////////////////////////////////////////////////////////////////////////////
  // Second stage: internal pipeline registers, or a straight path when unpiped.
  wire logic [63:0] st_alu   = mode_piped ? alu_pipe : alu_core;
  wire logic [63:0] st_mul   = mode_piped ? mul_pipe : mul_core;
  wire logic        st_alu_v = mode_piped ? alu_pipe_v : alu_go;
  wire logic        st_mul_v = mode_piped ? mul_pipe_v : mul_go;
  wire logic        st_cmp   = mode_piped ? alu_pipe_cmp : is_cmp;
  wire logic        st_sel   = mode_piped ? pipe_sel : output_source_select_bit;
  wire logic        st_hi    = mode_piped ? pipe_hi : output_high_half;
  // Mode is latched only while idle so latency never changes inside a vector.
  wire logic        idle = !op_v && !alu_pipe_v && !mul_pipe_v;
  wire logic        next_mode_piped = idle ? pipeline_enable : mode_piped;

  ////////////////////////////////////////////////////////////////////////////////
  // Output register stage and output multiplexer.
  wire logic [63:0] sum_now  = bypass_output_regs ? st_alu : alu_result_reg;
  wire logic [63:0] prod_now = bypass_output_regs ? st_mul : product_result_reg;
  wire logic        sum_vn   = bypass_output_regs ? (st_alu_v && !st_cmp) : sum_v;
  wire logic        prod_vn  = bypass_output_regs ? st_mul_v : prod_v;
  wire logic        sel_now  = bypass_output_regs ? st_sel : out_sel;
  wire logic        hi_now   = bypass_output_regs ? st_hi : out_hi;
  wire logic [63:0] out_word = (sel_now == fpvp_pkg::OUT_PROD) ? prod_now : sum_now;
  wire logic [31:0] out_half = hi_now ? out_word[63:32] : out_word[31:0];
  wire logic        out_v    = (sel_now == fpvp_pkg::OUT_PROD) ? prod_vn : sum_vn;

  assign result_output_bus = out_half;
  assign result_valid      = out_v;
  assign compare_equal     = cmp_eq_r;
  assign compare_a_greater = cmp_gt_r;
  assign status_valid      = cmp_fin;
  assign seq_active        = !idle;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operand_a_input_reg <= fpvp_pkg::RESET_WORD;
      operand_b_input_reg <= fpvp_pkg::RESET_WORD;
      in_valid            <= 1'b0;
      mode_piped          <= 1'b1;
    end else begin
      if (load_operands) begin
        operand_a_input_reg <= operand_a_in;
        operand_b_input_reg <= operand_b_in;
      end
      in_valid   <= load_operands;
      mode_piped <= next_mode_piped;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alu_pipe     <= fpvp_pkg::RESET_WIDE;
      mul_pipe     <= fpvp_pkg::RESET_WIDE;
      alu_pipe_v   <= 1'b0;
      mul_pipe_v   <= 1'b0;
      alu_pipe_cmp <= 1'b0;
      pipe_sel     <= fpvp_pkg::OUT_SUM;
      pipe_hi      <= 1'b0;
    end else begin
      alu_pipe     <= alu_core;
      mul_pipe     <= mul_core;
      alu_pipe_v   <= alu_go && mode_piped;
      mul_pipe_v   <= mul_go && mode_piped;
      alu_pipe_cmp <= is_cmp;
      pipe_sel     <= output_source_select_bit;
      pipe_hi      <= output_high_half;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alu_result_reg     <= fpvp_pkg::RESET_WIDE;
      product_result_reg <= fpvp_pkg::RESET_WIDE;
      sum_v              <= 1'b0;
      prod_v             <= 1'b0;
      out_sel            <= fpvp_pkg::OUT_SUM;
      out_hi             <= 1'b0;
    end else begin
      if (st_alu_v && !st_cmp) begin
        alu_result_reg <= st_alu;
      end
      if (st_mul_v) begin
        product_result_reg <= st_mul;
      end
      sum_v   <= st_alu_v && !st_cmp;
      prod_v  <= st_mul_v;
      out_sel <= st_sel;
      out_hi  <= st_hi;
    end
  end

  // Compare status is captured on the same edge as the output registers; a compare writes no numeric result.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_eq_r <= 1'b0;
      cmp_gt_r <= 1'b0;
      cmp_pend <= 1'b0;
      cmp_fin  <= 1'b0;
    end else begin
      if (st_alu_v && st_cmp) begin
        cmp_eq_r <= (st_alu == fpvp_pkg::RESET_WIDE);
        cmp_gt_r <= !st_alu[63] && (st_alu != fpvp_pkg::RESET_WIDE);
      end
      cmp_pend <= st_alu_v && st_cmp;
      cmp_fin  <= st_alu_v && st_cmp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  piped_add_lat_a: assert property (
    (mode_piped && !bypass_input_regs && !bypass_output_regs && load_operands &&
     alu_op_valid && alu_func == fpvp_pkg::ALU_ADD && $stable(mode_piped)) ##1
    ($stable(mode_piped) && $stable(bypass_output_regs)) ##1 $stable(mode_piped)
    |=> sum_v)
    else $error("Piped sum did not reach the sum register in time.");

  piped_out_lat_a: assert property (
    (mode_piped && !bypass_input_regs && !bypass_output_regs && load_operands && multiply_op)
    ##1 mode_piped ##1 (mode_piped && !bypass_output_regs)
    |=> prod_v)
    else $error("Piped product missing on the output clock.");

  unpiped_lat_a: assert property (
    (!mode_piped && !bypass_input_regs && !bypass_output_regs && load_operands && multiply_op)
    ##1 (!mode_piped && !bypass_output_regs) |=> prod_v)
    else $error("Unpiped product missing on the output clock.");

  unpiped_value_a: assert property (
    (!mode_piped && in_valid && multiply_op && !bypass_input_regs)
    |=> product_result_reg == $past(mul_core))
    else $error("Unpiped product did not complete in one cycle.");

  mode_static_a: assert property (
    seq_active |=> $stable(mode_piped))
    else $error("Pipeline mode changed during a vector sequence.");

  cmp_no_sum_a: assert property (
    (st_alu_v && st_cmp) |=> (status_valid && $stable(alu_result_reg)))
    else $error("Compare wrote a numeric result before its status.");

  out_half_a: assert property (
    (hi_now && sel_now == fpvp_pkg::OUT_PROD) |-> result_output_bus == prod_now[63:32])
    else $error("Output multiplexer chose the wrong half.");

  accept_each_a: assert property (
    load_operands |=> (operand_a_input_reg == $past(operand_a_in)))
    else $error("Operand pair was not accepted on this clock.");

  chain_feed_a: assert property (
    (chained_mode && alu_go && !mode_piped && !bypass_output_regs &&
     alu_func == fpvp_pkg::ALU_ADD && !alu_abs_b)
    |=> alu_result_reg == 64'($past(product_result_reg) + {{32{$past(op_b[31])}}, $past(op_b)}))
    else $error("Chained add did not use the product.");

  out_low_half_a: assert property (
    (!hi_now && sel_now == fpvp_pkg::OUT_SUM) |-> result_output_bus == sum_now[31:0])
    else $error("Output multiplexer chose the wrong half of the sum.");

  unpiped_add_a: assert property (
    (!mode_piped && !bypass_output_regs && op_v && alu_op_valid &&
     alu_func != fpvp_pkg::ALU_COMPARE) |=> sum_v)
    else $error("Unpiped ALU result missing on the output clock.");

  bypass_out_a: assert property (
    (bypass_output_regs && !hi_now && sel_now == fpvp_pkg::OUT_PROD)
    |-> result_output_bus == st_mul[31:0])
    else $error("Bypassed output did not show the stage two product.");

  accept_b_a: assert property (
    load_operands |=> (operand_b_input_reg == $past(operand_b_in)))
    else $error("Second operand was not accepted on this clock.");

  pipe_stage_a: assert property (
    (mode_piped && alu_go && !is_cmp) |=> alu_pipe_v)
    else $error("Piped sum skipped the internal pipeline register.");

  // The sum is rebuilt from the input registers, so a broken adder cannot hide here.
  unpiped_sum_a: assert property (
    (!mode_piped && in_valid && alu_op_valid && alu_func == fpvp_pkg::ALU_ADD &&
     !alu_abs_a && !alu_abs_b && !bypass_input_regs && !chained_mode)
    |=> alu_result_reg == $past({{32{operand_a_input_reg[31]}}, operand_a_input_reg} +
                                {{32{operand_b_input_reg[31]}}, operand_b_input_reg}))
    else $error("Unpiped sum did not complete in one cycle.");

  piped_mul_a: assert property (
    (mode_piped && mul_pipe_v) |=> product_result_reg == $past(mul_pipe))
    else $error("Piped product did not move to the product register.");

  cmp_hold_a: assert property (
    !(st_alu_v && st_cmp) |=> ($stable(compare_equal) && $stable(compare_a_greater)))
    else $error("Compare status changed without a compare.");

  piped_run_c: cover property (mode_piped && load_operands ##1 load_operands ##2 sum_v);
  unpiped_run_c: cover property (!mode_piped && load_operands && multiply_op ##1 prod_v);
  compare_c: cover property (is_cmp && op_v ##[1:3] status_valid);
  chain_c: cover property (chained_mode && alu_go && mul_go);
  bypass_c: cover property (bypass_output_regs && result_valid);
endmodule

// *** test/fpvp_seq_model.sv ***
// Sequencer model that streams operand pairs and operation requests.
`timescale 1ns/1ns
module fpvp_seq_model (
  input  wire logic   clk,
  output logic [31:0] operand_a_in,
  output logic [31:0] operand_b_in,
  output logic        load_operands,
  output logic        alu_op_valid,
  output logic        multiply_op,
  output logic        output_source_select_bit
);
  initial begin
    operand_a_in = 32'h0;
    operand_b_in = 32'h0;
    load_operands = 1'b0;
    alu_op_valid = 1'b0;
    multiply_op = 1'b0;
    output_source_select_bit = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Requests trail their pair by a cycle; an idle bus shows the inverse, not stale data.
  task automatic run(input int n, input logic mul, input logic [31:0] a0,
                     input logic [31:0] b0);
    for (int i = 0; i <= n; i++) begin
      @(negedge clk);
      load_operands = (i < n);
      operand_a_in = (i < n) ? a0 + 32'(i) : ~operand_a_in;
      operand_b_in = (i < n) ? b0 : ~operand_b_in;
      alu_op_valid = (i > 0) && !mul;
      multiply_op = (i > 0) && mul;
      output_source_select_bit = mul ? fpvp_pkg::OUT_PROD : fpvp_pkg::OUT_SUM;
    end
    @(negedge clk);
    alu_op_valid = 1'b0;
    multiply_op = 1'b0;
  endtask
endmodule

// *** test/fpvp_datapath_test.sv ***
// Self-checking bench for the vector datapath.
`timescale 1ns/1ns
module fpvp_datapath_test;
  logic        clk, rstn, load_operands, alu_op_valid, alu_abs_a, alu_abs_b, multiply_op;
  logic        output_source_select_bit, output_high_half, pipeline_enable;
  logic        chained_mode, bypass_input_regs, bypass_output_regs;
  logic        result_valid, compare_equal, compare_a_greater, status_valid;
  logic [2:0]  alu_func, mul_func;
  logic [31:0] operand_a_in, operand_b_in, result_output_bus;
  int          err_total, total_checks;
  fpvp_datapath fpvp_datapath_i (.clk(clk), .rstn(rstn), .operand_a_in(operand_a_in),
    .operand_b_in(operand_b_in), .load_operands(load_operands), .alu_op_valid(alu_op_valid),
    .alu_func(alu_func), .alu_abs_a(alu_abs_a), .alu_abs_b(alu_abs_b),
    .multiply_op(multiply_op), .mul_func(mul_func), .chained_mode(chained_mode),
    .output_source_select_bit(output_source_select_bit), .output_high_half(output_high_half),
    .pipeline_enable(pipeline_enable), .bypass_input_regs(bypass_input_regs),
    .bypass_output_regs(bypass_output_regs),
    .result_output_bus(result_output_bus), .result_valid(result_valid),
    .compare_equal(compare_equal), .compare_a_greater(compare_a_greater),
    .status_valid(status_valid));
  fpvp_seq_model fpvp_seq_model_i (.clk(clk), .operand_a_in(operand_a_in),
    .operand_b_in(operand_b_in), .load_operands(load_operands), .alu_op_valid(alu_op_valid),
    .multiply_op(multiply_op), .output_source_select_bit(output_source_select_bit));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Integer stand-in arithmetic on 64 bits, then the selected half.
  function automatic logic [31:0] expv(input logic mul, input logic [31:0] a,
                                       input logic [31:0] b);
    longint sa, sb, r;
    sa = longint'($signed(a));
    sb = longint'($signed(b));
    if ((mul ? mul_func >= 3'h4 : alu_abs_a) && sa < 0) sa = -sa;
    if ((mul ? mul_func >= 3'h2 : alu_abs_b) && sb < 0) sb = -sb;
    if (mul) r = mul_func[0] ? -(sa * sb) : sa * sb;
    else if (alu_func == fpvp_pkg::ALU_ADD) r = sa + sb;
    else if (alu_func == fpvp_pkg::ALU_A_SUB_B) r = sa - sb;
    else r = sb - sa;
    return output_high_half ? r[63:32] : r[31:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_vec(input int n, input logic mul, input logic cmp, input logic [2:0] f,
                         input logic [1:0] ab, input logic hi, input logic [31:0] a0,
                         input logic [31:0] b0, input int lat, input logic flip);
    int j;
    logic [31:0] a;
    j = 0;
    @(negedge clk);
    alu_func = f;
    mul_func = f;
    {alu_abs_a, alu_abs_b} = ab;
    output_high_half = hi;
    fork
      fpvp_seq_model_i.run(n, mul, a0, b0);
      if (flip) begin
        repeat (3) @(negedge clk);
        pipeline_enable = 1'b0;
      end
      begin
        @(negedge clk);
        for (int e = 0; e < n + 6; e++) begin
          @(posedge clk);
          #10;
          if (cmp) begin
            check("sum valid on compare", result_valid, 1'b0);
            if (status_valid === 1'b1) begin
              a = a0 + 32'(j);
              check("equal", compare_equal, a == b0);
              check("greater", compare_a_greater, $signed(a) > $signed(b0));
              j++;
            end
          end else begin
            check("valid", result_valid, e >= lat && e < lat + n);
            if (e >= lat && e < lat + n) begin
              a = a0 + 32'(e - lat);
              check("result", result_output_bus, expv(mul, a, b0));
            end
          end
        end
      end
    join
    if (cmp) check("status count", j, n);
  endtask
  task automatic set_mode(input logic piped);
    @(negedge clk);
    pipeline_enable = piped;
    repeat (3) @(negedge clk);
  endtask
  task automatic sc_add_piped();
    set_mode(1'b1);
    for (int f = 0; f < 3; f++) begin
      for (int m = 0; m < 4; m++) begin
        run_vec(3, 1'b0, 1'b0, 3'(f), 2'(m), 1'b0, 32'hffff_fffe, 32'h1, 2, 1'b0);
      end
    end
  endtask
  task automatic sc_mul_unpiped();
    set_mode(1'b0);
    for (int f = 0; f < 6; f++) begin
      run_vec(4, 1'b1, 1'b0, 3'(f), 2'h0, 1'b0, 32'hffff_fffe, 32'hffff_fffd, 1, 1'b0);
    end
    run_vec(3, 1'b0, 1'b0, 3'h0, 2'h0, 1'b0, 32'h7, 32'h2, 1, 1'b0);
  endtask
  task automatic sc_high_half();
    set_mode(1'b1);
    run_vec(3, 1'b1, 1'b0, 3'h0, 2'h0, 1'b1, 32'h0001_0000, 32'h0003_0000, 2, 1'b0);
    run_vec(3, 1'b0, 1'b0, 3'h0, 2'h0, 1'b1, 32'hffff_fffe, 32'h1, 2, 1'b0);
  endtask
  task automatic sc_compare();
    run_vec(4, 1'b0, 1'b1, fpvp_pkg::ALU_COMPARE, 2'h0, 1'b0, 32'hffff_ffff, 32'h1, 2, 1'b0);
  endtask
  task automatic sc_mode_static();
    set_mode(1'b1);
    run_vec(5, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 32'h5, 32'h7, 2, 1'b1);
    set_mode(1'b1);
  endtask
  // The chained add takes the product left by the previous vector as its left operand.
  task automatic sc_chain();
    set_mode(1'b0);
    run_vec(1, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 32'h7, 32'h6, 1, 1'b0);
    @(negedge clk);
    chained_mode = 1'b1;
    alu_func = fpvp_pkg::ALU_ADD;
    fork
      fpvp_seq_model_i.run(1, 1'b0, 32'h9, 32'h5);
      begin
        @(negedge clk);
        repeat (2) @(posedge clk);
        #10;
        check("chain valid", result_valid, 1'b1);
        check("chain sum", result_output_bus, 32'h0000_002f);
      end
    join
    chained_mode = 1'b0;
  endtask
  task automatic sc_bypass();
    set_mode(1'b1);
    bypass_output_regs = 1'b1;
    run_vec(3, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 32'h4, 32'h3, 1, 1'b0);
    @(negedge clk);
    bypass_output_regs = 1'b0;
  endtask
  initial begin
    rstn = 1'b0;
    alu_func = 3'h0;
    mul_func = 3'h0;
    alu_abs_a = 1'b0;
    alu_abs_b = 1'b0;
    output_high_half = 1'b0;
    pipeline_enable = 1'b1;
    chained_mode = 1'b0;
    bypass_input_regs = 1'b0;
    bypass_output_regs = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(negedge clk);
    check("valid in reset", {result_valid, status_valid}, 32'h0);
    rstn = 1'b1;
    sc_add_piped();
    sc_mul_unpiped();
    sc_high_half();
    sc_compare();
    sc_mode_static();
    sc_chain();
    sc_bypass();
    finish_test();
  end
endmodule
